// ---- logic/tsm_status_regs.vh ----
`ifndef TSM_STATUS_REGS_VH
`define TSM_STATUS_REGS_VH
// register byte offsets on the apb bus
`define TSM_OFF_CTRL      8'h00
`define TSM_OFF_ENABLE    8'h04
`define TSM_OFF_ASSIGN0   8'h08
`define TSM_OFF_ASSIGN1   8'h0C
`define TSM_OFF_ASSIGN2   8'h10
`define TSM_OFF_ASSIGN3   8'h14
`define TSM_OFF_DAQRUN    8'h18
`define TSM_OFF_MERGED    8'h1C
`define TSM_OFF_FAULT     8'h20
`define TSM_OFF_BADCODE   8'h24
`define TSM_OFF_IRQSTAT   8'h28
`define TSM_OFF_IRQMASK   8'h2C
`define TSM_OFF_DAQOUT    8'h30
// control register fields
`define TSM_CTRL_MAJORITY 0
`define TSM_CTRL_STANDALONE 1
// reset values
`define TSM_RST_CTRL      32'h0000_0000
`define TSM_RST_ENABLE    32'hFFFF_FFFF
`define TSM_RST_ASSIGN    32'h0000_0000
`define TSM_RST_DAQRUN    16'h0000
`define TSM_RST_IRQMASK   3'h0
// interrupt status bits
`define TSM_IRQ_OOS       0
`define TSM_IRQ_ERROR     1
`define TSM_IRQ_BADCODE   2
// channel bit positions: ready, busy, out-of-sync, warning
`define TSM_BIT_READY     3
`define TSM_BIT_BUSY      2
`define TSM_BIT_OOS       1
`define TSM_BIT_WARN      0
// legal channel codes
`define TSM_CODE_DISC0    4'h0
`define TSM_CODE_WARN     4'h1
`define TSM_CODE_OOS      4'h2
`define TSM_CODE_BUSY     4'h4
`define TSM_CODE_READY    4'h8
`define TSM_CODE_IDLE     4'hA
`define TSM_CODE_ERROR    4'hC
`define TSM_CODE_DISC1    4'hF
// controller run states per daq partition
`define TSM_RUN_DISC      2'h0
`define TSM_RUN_IDLE      2'h1
`define TSM_RUN_ACTIVE    2'h2
`define TSM_RUN_ERROR     2'h3
// sizes
`define TSM_NPART         32
`define TSM_NDAQ          8
`define TSM_NLOCAL        6
`endif

// ---- logic/tsm_merge_node.v ----
`timescale 1ns/10ps
`include "tsm_status_regs.vh"

// combines 32 status channels by or/and or by majority, flags illegal codes
module tsm_merge_node (
    // incoming channels, channel i in bits 4i+3..4i
    input  wire [127:0] chanIn,
    input  wire [31:0]  chanEnable,
    // combining algorithm select
    input  wire         majority,
    // combined status and per-input illegal code flags
    output reg  [3:0]   merged,
    output wire [31:0]  badCode
);
    // per-input illegal code detection
    genvar g;
    generate
        for (g = 0; g < `TSM_NPART; g = g + 1) begin : gChan
            wire [3:0] code = chanIn[4*g+3:4*g];
            assign badCode[g] = chanEnable[g] &
                ~((code == `TSM_CODE_DISC0) | (code == `TSM_CODE_WARN) |
                  (code == `TSM_CODE_OOS)   | (code == `TSM_CODE_BUSY) |
                  (code == `TSM_CODE_READY) | (code == `TSM_CODE_IDLE) |
                  (code == `TSM_CODE_ERROR) | (code == `TSM_CODE_DISC1));
        end
    endgenerate

    // vote counters and and/or reductions over enabled inputs
    integer i;
    integer b;
    reg [5:0] cnt [0:3];
    reg [5:0] nEn;
    reg [3:0] anyBit;
    reg [3:0] allBit;
    always @* begin
        nEn = 6'h00;
        anyBit = 4'h0;
        allBit = 4'hF;
        for (b = 0; b < 4; b = b + 1) begin
            cnt[b] = 6'h00;
        end
        for (i = 0; i < `TSM_NPART; i = i + 1) begin
            if (chanEnable[i]) begin
                nEn = nEn + 6'h01;
                for (b = 0; b < 4; b = b + 1) begin
                    cnt[b] = cnt[b] + {5'h00, chanIn[4*i+b]};
                    anyBit[b] = anyBit[b] | chanIn[4*i+b];
                    allBit[b] = allBit[b] & chanIn[4*i+b];
                end
            end
        end
        if (majority) begin
            // a level wins when more than half the enabled inputs show it
            for (b = 0; b < 4; b = b + 1) begin
                merged[b] = ({cnt[b], 1'b0} > {1'b0, nEn});
            end
        end else begin
            // ready is and, busy/oos/warning are or
            merged = {allBit[`TSM_BIT_READY], anyBit[`TSM_BIT_BUSY],
                      anyBit[`TSM_BIT_OOS], anyBit[`TSM_BIT_WARN]};
        end
    end
endmodule // tsm_merge_node

// ---- logic/tsm_status_merger.v ----
`timescale 1ns/10ps
`include "tsm_status_regs.vh"

module tsm_status_merger (
    // clock and reset
    input  wire         clk,
    input  wire         reset_n,
    // apb slave
    input  wire         psel,
    input  wire         penable,
    input  wire         pwrite,
    input  wire [7:0]   paddr,
    input  wire [31:0]  pwdata,
    output reg  [31:0]  prdata,
    output wire         pready,
    output wire         pslverr,
    // partition channels from the merging tree
    input  wire [127:0] partStatus,
    // supervisor channels, one per daq partition
    input  wire [31:0]  supStatus,
    // combined node output up the tree
    output reg  [3:0]   mergedStatus,
    // daq partition outputs to the supervisor
    output reg  [31:0]  daqStatus,
    // local controller channel to the supervisor
    output reg  [3:0]   localStatus,
    // per-partition out-of-sync or error flags to the supervisor
    output reg  [31:0]  syncFault,
    // level interrupt
    output wire         irq
);
    // maps four aggregated levels onto a legal code
    // the run state wins over the partition levels, so a
    // group that is not started never reports ready
    // priority when active: oos, busy, warning, ready
    function [3:0] encodeStatus;
        input [1:0] runState;
        input       rdy;
        input       bsy;
        input       oos;
        input       wrn;
        begin
            case (runState)
                `TSM_RUN_DISC:   encodeStatus = `TSM_CODE_DISC0;
                `TSM_RUN_IDLE:   encodeStatus = `TSM_CODE_IDLE;
                `TSM_RUN_ERROR:  encodeStatus = `TSM_CODE_ERROR;
                `TSM_RUN_ACTIVE: begin
                    if (oos) begin
                        encodeStatus = `TSM_CODE_OOS;
                    end else if (bsy) begin
                        encodeStatus = `TSM_CODE_BUSY;
                    end else if (wrn) begin
                        encodeStatus = `TSM_CODE_WARN;
                    end else if (rdy) begin
                        encodeStatus = `TSM_CODE_READY;
                    end else begin
                        encodeStatus = `TSM_CODE_BUSY; // not all ready holds triggers
                    end
                end
                default: encodeStatus = `TSM_CODE_DISC0;
            endcase
        end
    endfunction

    // register map, one aligned word each:
    //   control, channel enable, four partition maps,
    //   daq run states, merged status, fault flags,
    //   illegal code history, irq status, irq mask, daq outputs
    // software registers
    // all but badCodeHist and irqStat written only in the access cycle of a bus write
    reg  [31:0] ctrl;        // algorithm and standalone selects
    reg  [31:0] chanEnable;  // inputs taking part in the merge
    reg  [31:0] assign0;     // partition to daq maps, 4 bits each
    reg  [31:0] assign1;
    reg  [31:0] assign2;
    reg  [31:0] assign3;
    reg  [15:0] daqRun;      // controller state per daq, 2 bits each
    reg  [31:0] badCodeHist; // sticky illegal code history
    reg  [2:0]  irqStat;     // sticky events
    reg  [2:0]  irqMask;     // event enables

    // bus phase decode
    // psel without penable is the setup cycle
    // read data is fetched in setup
    // writes and read-clears land in access
    wire        setupPh  = psel & ~penable;
    wire        accessPh = psel & penable;
    wire        wrEn     = accessPh & pwrite;
    wire        rdEn     = accessPh & ~pwrite;
    reg         addrHit;
    reg  [31:0] next_prdata;

    // merge node over all 32 partition channels
    // the result is raw: mixed inputs may give a forbidden code
    // or versus majority comes from the control register
    // illegal codes are seen per input, before merging
    wire [3:0]  nodeMerged;
    wire [31:0] badCodeNow;
    tsm_merge_node uNode (
        .chanIn     (partStatus),
        .chanEnable (chanEnable),
        .majority   (ctrl[`TSM_CTRL_MAJORITY]),
        .merged     (nodeMerged),
        .badCode    (badCodeNow)
    );

    // all four assignment words as one vector, partition p in bits 4p+3..4p
    // a partition with bit 3 of its map entry low joins no daq group, whatever chanEnable holds
    // maps are set by software before a run starts
    wire [127:0] assignAll = {assign3, assign2, assign1, assign0};

    // per-partition fault detection: out-of-sync or error code
    // masked partitions never raise a fault
    // the supervisor reads these bits to pick its resets
    // the flag follows the input one cycle late, not sticky
    wire [31:0] faultNow;
    genvar p;
    generate
        for (p = 0; p < `TSM_NPART; p = p + 1) begin : gPart
            wire [3:0] code = partStatus[4*p+3:4*p];
            assign faultNow[p] = chanEnable[p] &
                ((code == `TSM_CODE_OOS) | (code == `TSM_CODE_ERROR));
        end
    endgenerate

    // per-daq aggregation, one identical unit for each daq partition
    // the supervisor channel acts as one more member: its ready
    // joins the and, its other levels join the or
    // a group with no members follows the supervisor alone
    wire [31:0] next_daqStatus;
    genvar d;
    generate
        for (d = 0; d < `TSM_NDAQ; d = d + 1) begin : gDaq
            reg       rdy;
            reg       bsy;
            reg       oos;
            reg       wrn;
            reg       member;
            integer   k;
            wire [3:0] sup = supStatus[4*d+3:4*d];
            always @* begin
                rdy = sup[`TSM_BIT_READY];
                bsy = sup[`TSM_BIT_BUSY];
                oos = sup[`TSM_BIT_OOS];
                wrn = sup[`TSM_BIT_WARN];
                member = 1'b0;
                for (k = 0; k < `TSM_NPART; k = k + 1) begin
                    // bit 3 enables the map entry, bits 2..0 name the daq
                    // each partition names one daq, so units never share it
                    member = assignAll[4*k+3] & (assignAll[4*k+2 -: 3] == d);
                    if (member) begin
                        rdy = rdy & partStatus[4*k+`TSM_BIT_READY];
                        bsy = bsy | partStatus[4*k+`TSM_BIT_BUSY];
                        oos = oos | partStatus[4*k+`TSM_BIT_OOS];
                        wrn = wrn | partStatus[4*k+`TSM_BIT_WARN];
                    end
                end
            end
            // own control state joins the partition levels
            // idle, error and disconnected come from software alone
            // the active state lets the levels through
            assign next_daqStatus[4*d+3:4*d] =
                encodeStatus(daqRun[2*d+1:2*d], rdy, bsy, oos, wrn);
        end
    endgenerate

    // local controller view over the first six partitions
    // no enable mask here: the local controller always
    // owns the first six partition inputs
    // fixed or/and rule only, no majority
    reg        locRdy;
    reg        locBsy;
    reg        locOos;
    reg        locWrn;
    integer    j;
    always @* begin
        locRdy = 1'b1;
        locBsy = 1'b0;
        locOos = 1'b0;
        locWrn = 1'b0;
        for (j = 0; j < `TSM_NLOCAL; j = j + 1) begin
            locRdy = locRdy & partStatus[4*j+`TSM_BIT_READY];
            locBsy = locBsy | partStatus[4*j+`TSM_BIT_BUSY];
            locOos = locOos | partStatus[4*j+`TSM_BIT_OOS];
            locWrn = locWrn | partStatus[4*j+`TSM_BIT_WARN];
        end
    end
    // only in standalone mode does the local channel carry status
    // otherwise it shows disconnected and the supervisor
    // ignores it while the central controller is in charge
    wire [3:0] next_localStatus = ctrl[`TSM_CTRL_STANDALONE] ?
        encodeStatus(`TSM_RUN_ACTIVE, locRdy, locBsy, locOos, locWrn) :
        `TSM_CODE_DISC0;

    // status outputs refreshed on every clock edge
    // one flop stage hides glitches of the wide and/or trees
    // inputs are synchronous to this clock, no synchroniser
    // reset shows the disconnected code on every channel
    // outputs follow the inputs exactly one edge later
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            mergedStatus <= 4'h0;
            daqStatus    <= 32'h0000_0000;
            localStatus  <= 4'h0;
            syncFault    <= 32'h0000_0000;
        end else begin
            mergedStatus <= nodeMerged;
            daqStatus    <= next_daqStatus;
            localStatus  <= next_localStatus;
            syncFault    <= faultNow;
        end
    end

    // events feeding the sticky interrupt status
    // an oos event needs a real oos or error input behind the merged
    // code, so a forbidden mix reading as oos is not counted
    // events are levels: they set their bit on every cycle
    // in which the condition stands
    wire [2:0] evt;
    assign evt[`TSM_IRQ_OOS]     = |(faultNow & ~badCodeNow) &
                                   (nodeMerged == `TSM_CODE_OOS);
    assign evt[`TSM_IRQ_ERROR]   = (nodeMerged == `TSM_CODE_ERROR);
    assign evt[`TSM_IRQ_BADCODE] = |badCodeNow;

    // level interrupt while any unmasked status bit is set
    // the line drops as soon as software clears the bit
    // the mask acts at the output only, status still records
    assign irq = |(irqStat & irqMask);

    // read data mux and address decode
    // only aligned words are mapped, other offsets error
    // sticky registers read back the value before the clear
    // run states read back in the low half, upper half zero
    always @* begin
        addrHit = 1'b1;
        next_prdata = 32'h0000_0000;
        case (paddr)
            `TSM_OFF_CTRL:    next_prdata = ctrl;
            `TSM_OFF_ENABLE:  next_prdata = chanEnable;
            `TSM_OFF_ASSIGN0: next_prdata = assign0;
            `TSM_OFF_ASSIGN1: next_prdata = assign1;
            `TSM_OFF_ASSIGN2: next_prdata = assign2;
            `TSM_OFF_ASSIGN3: next_prdata = assign3;
            `TSM_OFF_DAQRUN:  next_prdata = {16'h0000, daqRun};
            `TSM_OFF_MERGED:  next_prdata = {28'h0000000, mergedStatus};
            `TSM_OFF_FAULT:   next_prdata = syncFault;
            `TSM_OFF_BADCODE: next_prdata = badCodeHist;
            `TSM_OFF_IRQSTAT: next_prdata = {29'h00000000, irqStat};
            `TSM_OFF_IRQMASK: next_prdata = {29'h00000000, irqMask};
            `TSM_OFF_DAQOUT:  next_prdata = daqStatus;
            default: begin
                addrHit = 1'b0; // unmapped reads zero and errors
                next_prdata = 32'h0000_0000;
            end
        endcase
    end

    // zero wait state answer; error on unmapped address
    // every access lasts one cycle, so pready needs no state
    // unmapped writes change nothing and still error
    // writes to read-only offsets are dropped with no error
    assign pready  = accessPh;
    assign pslverr = accessPh & ~addrHit;

    // read data captured in the setup cycle, held through access
    // early capture gives settled data at the access edge
    // the captured word tells the clear logic what was seen
    // write transfers leave the captured word alone
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            prdata <= 32'h0000_0000;
        end else if (setupPh & ~pwrite) begin
            prdata <= next_prdata;
        end
    end

    // writable registers
    // unused control bits stay zero, so reads show
    // only the fields that exist
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ctrl       <= `TSM_RST_CTRL;
            chanEnable <= `TSM_RST_ENABLE;
            assign0    <= `TSM_RST_ASSIGN;
            assign1    <= `TSM_RST_ASSIGN;
            assign2    <= `TSM_RST_ASSIGN;
            assign3    <= `TSM_RST_ASSIGN;
            daqRun     <= `TSM_RST_DAQRUN;
            irqMask    <= `TSM_RST_IRQMASK;
        end else if (wrEn) begin
            case (paddr)
                `TSM_OFF_CTRL:    ctrl <= {30'h00000000, pwdata[1:0]};
                `TSM_OFF_ENABLE:  chanEnable <= pwdata;
                `TSM_OFF_ASSIGN0: assign0 <= pwdata;
                `TSM_OFF_ASSIGN1: assign1 <= pwdata;
                `TSM_OFF_ASSIGN2: assign2 <= pwdata;
                `TSM_OFF_ASSIGN3: assign3 <= pwdata;
                `TSM_OFF_DAQRUN:  daqRun <= pwdata[15:0];
                `TSM_OFF_IRQMASK: irqMask <= pwdata[2:0];
                default: begin
                    // read-only or unmapped: no effect
                end
            endcase
        end
    end

    // sticky history and interrupt status; read clears, new event wins
    // the read word was taken at setup, a cycle before the clear;
    // a bit set in between was never seen by software, so only
    // the bits the read showed are cleared, and an event in the
    // clearing cycle sets its bit again
    wire        clrHist  = rdEn & (paddr == `TSM_OFF_BADCODE);
    wire        clrIrq   = rdEn & (paddr == `TSM_OFF_IRQSTAT);
    // bits kept through a clear: all the read did not report
    wire [31:0] histKeep = clrHist ? ~prdata : 32'hFFFF_FFFF;
    wire [2:0]  irqKeep  = clrIrq ? ~prdata[2:0] : 3'h7;
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            badCodeHist <= 32'h0000_0000;
            irqStat     <= 3'h0;
        end else begin
            badCodeHist <= (badCodeHist & histKeep) | badCodeNow;
            irqStat     <= (irqStat & irqKeep) | evt;
        end
    end
endmodule // tsm_status_merger

// ---- tb/tsm_status_merger_chk.sv ----
`timescale 1ns/10ps
// port-level checks for the status merger
module tsm_status_merger_chk (
    // clock and reset
    input logic         clk,
    input logic         reset_n,
    // apb
    input logic         psel,
    input logic         penable,
    input logic         pwrite,
    input logic [7:0]   paddr,
    input logic [31:0]  pwdata,
    input logic [31:0]  prdata,
    input logic         pready,
    input logic         pslverr,
    // status channels
    input logic [127:0] partStatus,
    input logic [31:0]  supStatus,
    input logic [3:0]   mergedStatus,
    input logic [31:0]  daqStatus,
    input logic [3:0]   localStatus,
    input logic [31:0]  syncFault,
    input logic         irq
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    // ready and busy levels gathered per partition
    logic [31:0] rdyBits;
    logic [31:0] busyBits;
    always_comb begin
        for (int i = 0; i < 32; i++) begin
            rdyBits[i] = partStatus[4*i+3];
            busyBits[i] = partStatus[4*i+2];
        end
    end
    property p_pready_acc; psel && penable |-> pready; endproperty
    a_pready_acc: assert property (p_pready_acc) else $error("no zero-wait ready");
    property p_idle_quiet; !psel |-> !pready && !pslverr; endproperty
    a_idle_quiet: assert property (p_idle_quiet) else $error("apb answer while idle");
    property p_unmapped;
        psel && penable && !pwrite && paddr > 8'h30 |-> pslverr && prdata == 32'h0;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");
    property p_unmapped_wr; psel && penable && pwrite && paddr > 8'h30 |-> pslverr; endproperty
    a_unmapped_wr: assert property (p_unmapped_wr) else $error("unmapped write not refused");
    property p_err_access; pslverr |-> psel && penable; endproperty
    a_err_access: assert property (p_err_access) else $error("error outside access");
    property p_prdata_hold; !(psel && !penable && !pwrite) |=> $stable(prdata); endproperty
    a_prdata_hold: assert property (p_prdata_hold) else $error("read data moved");
    property p_fault_cause;
        syncFault[0] |-> $past(partStatus[3:0]) == 4'h2 || $past(partStatus[3:0]) == 4'hC;
    endproperty
    a_fault_cause: assert property (p_fault_cause) else $error("fault without cause");
    property p_local_ready; $past(rdyBits[5:0]) != 6'h3F |-> !localStatus[3]; endproperty
    a_local_ready: assert property (p_local_ready) else $error("local ready wrong");
    property p_merged_busy; $past(busyBits) == 32'h0 |-> !mergedStatus[2]; endproperty
    a_merged_busy: assert property (p_merged_busy) else $error("merged busy wrong");
    property p_merged_ready;
        $past(reset_n) && $past(rdyBits) == 32'hFFFF_FFFF |-> mergedStatus[3];
    endproperty
    a_merged_ready: assert property (p_merged_ready) else $error("merged ready lost");
endmodule // tsm_status_merger_chk

bind tsm_status_merger tsm_status_merger_chk chk_u (.clk, .reset_n, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .partStatus, .supStatus, .mergedStatus,
    .daqStatus, .localStatus, .syncFault, .irq);

// ---- tb/tsm_far_side.sv ----
`timescale 1ns/10ps
// partitions and supervisor on the far side, driving status levels
module tsm_far_side (
    // clock
    input  logic         clk,
    // partition pattern: every channel fill, one channel odd
    input  logic [3:0]   fillCode,
    input  logic [4:0]   oddCh,
    input  logic [3:0]   oddCode,
    // supervisor requests per daq partition
    input  logic [7:0]   supWarn,
    input  logic [7:0]   supFault,
    // status levels
    output logic [127:0] partStatus,
    output logic [31:0]  supStatus
);
    // levels change just after an edge and hold while the state is valid
    always @(posedge clk) begin
        for (int p = 0; p < 32; p++) begin
            partStatus[4*p +: 4] <= (p == oddCh) ? oddCode : fillCode;
        end
        for (int d = 0; d < 8; d++) begin
            if (supFault[d]) begin
                supStatus[4*d +: 4] <= 4'h4;
            end else if (supWarn[d]) begin
                supStatus[4*d +: 4] <= 4'h1;
            end else begin
                supStatus[4*d +: 4] <= 4'h8;
            end
        end
    end
endmodule // tsm_far_side

// ---- tb/tsm_status_merger_bench.sv ----
`timescale 1ns/10ps
`include "tsm_status_regs.vh"
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin fails++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
// apb-driven bench for the status merger
module tsm_status_merger_bench;
    logic         clk, reset_n, psel, penable, pwrite, pready, pslverr, irq;
    logic [7:0]   paddr, supWarn, supFault;
    logic [31:0]  pwdata, prdata, supStatus, daqStatus, syncFault;
    logic [127:0] partStatus;
    logic [3:0]   mergedStatus, localStatus, fillCode, oddCode;
    logic [4:0]   oddCh;
    logic [32:0]  junk;
    int           fails, comparisons;
    logic [3:0]   legal [8] = '{`TSM_CODE_DISC0, `TSM_CODE_WARN, `TSM_CODE_OOS,
        `TSM_CODE_BUSY, `TSM_CODE_READY, `TSM_CODE_IDLE, `TSM_CODE_ERROR, `TSM_CODE_DISC1};
    tsm_status_merger dut_u (.clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .partStatus(partStatus), .supStatus(supStatus),
        .mergedStatus(mergedStatus), .daqStatus(daqStatus), .localStatus(localStatus),
        .syncFault(syncFault), .irq(irq));
    tsm_far_side far_u (.clk(clk), .fillCode(fillCode), .oddCh(oddCh), .oddCode(oddCode),
        .supWarn(supWarn), .supFault(supFault), .partStatus(partStatus),
        .supStatus(supStatus));
    // 40 MHz clock
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // verdict and end of run
    task tally_and_finish;
        $display("comparisons=%0d fails=%0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // one apb transfer; returns {pslverr, prdata} from the ready edge
    task apb(input logic [7:0] a, input logic w, input logic [31:0] d, output logic [32:0] q);
        int n;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (pready !== 1'b1) begin
            fails++;
            tally_and_finish;
        end
        q = {pslverr, prdata};
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        apb(a, 1'b1, d, junk);
    endtask
    task rd(input logic [7:0] a, input logic e, input logic [31:0] d);
        apb(a, 1'b0, 32'h0, junk);
        `CHK(junk, {e, d})
    endtask
    // set the partition pattern and let both register stages settle
    task put(input logic [3:0] f, input logic [4:0] c, input logic [3:0] o);
        fillCode <= f;
        oddCh <= c;
        oddCode <= o;
        repeat (3) @(posedge clk);
    endtask
    // main sequence
    initial begin
        {reset_n, psel, penable, pwrite, paddr, pwdata} = '0;
        {fillCode, oddCh, oddCode, supWarn, supFault} = {4'h8, 5'h1F, 4'h8, 16'h0};
        fails = 0;
        comparisons = 0;
        repeat (8) @(posedge clk);
        reset_n <= 1'b1;
        @(posedge clk);
        rd(`TSM_OFF_CTRL, 1'b0, `TSM_RST_CTRL);
        rd(`TSM_OFF_ENABLE, 1'b0, `TSM_RST_ENABLE);
        rd(`TSM_OFF_IRQMASK, 1'b0, 32'h0);
        rd(`TSM_OFF_DAQRUN, 1'b0, 32'h0);
        rd(8'h40, 1'b1, 32'h0);
        apb(8'h44, 1'b1, 32'hFFFF_FFFF, junk);
        `CHK(junk[32], 1'b1)
        for (int i = 0; i < 8; i++) begin
            put(legal[i], 5'h1F, legal[i]);
            `CHK(mergedStatus, legal[i])
        end
        rd(`TSM_OFF_BADCODE, 1'b0, 32'h0);
        put(4'h8, 5'h1F, 4'h8);
        apb(`TSM_OFF_IRQSTAT, 1'b0, 32'h0, junk);
        put(4'h8, 5'h05, 4'h4);
        `CHK(mergedStatus, 4'h4)
        wr(`TSM_OFF_CTRL, 32'h1);
        put(4'h8, 5'h05, 4'h4);
        `CHK(mergedStatus, 4'h8)
        wr(`TSM_OFF_CTRL, 32'h0);
        put(4'h8, 5'h07, 4'h5);
        put(4'h8, 5'h1F, 4'h8);
        rd(`TSM_OFF_BADCODE, 1'b0, 32'h80);
        rd(`TSM_OFF_BADCODE, 1'b0, 32'h0);
        `CHK(irq, 1'b0)
        wr(`TSM_OFF_IRQMASK, 32'h4);
        `CHK(irq, 1'b1)
        rd(`TSM_OFF_IRQSTAT, 1'b0, 32'h4);
        `CHK(irq, 1'b0)
        put(4'h8, 5'h03, 4'h2);
        `CHK(syncFault, 32'h8)
        `CHK(mergedStatus, 4'h2)
        rd(`TSM_OFF_FAULT, 1'b0, 32'h8);
        rd(`TSM_OFF_IRQSTAT, 1'b0, 32'h1);
        wr(`TSM_OFF_CTRL, 32'h2);
        put(4'h8, 5'h02, 4'h4);
        `CHK(localStatus, 4'h4)
        wr(`TSM_OFF_CTRL, 32'h0);
        put(4'h8, 5'h1F, 4'h8);
        `CHK(localStatus, 4'h0)
        wr(`TSM_OFF_ASSIGN0, 32'h0000_00AA);
        wr(`TSM_OFF_DAQRUN, 32'h0000_C420);
        put(4'h8, 5'h1F, 4'h8);
        `CHK(daqStatus, 32'hC0A0_0800)
        put(4'h8, 5'h01, 4'h4);
        `CHK(daqStatus, 32'hC0A0_0400)
        supWarn <= 8'h04;
        put(4'h8, 5'h1F, 4'h8);
        `CHK(daqStatus, 32'hC0A0_0100)
        supFault <= 8'h04;
        put(4'h8, 5'h1F, 4'h8);
        `CHK(daqStatus, 32'hC0A0_0400)
        rd(`TSM_OFF_DAQOUT, 1'b0, 32'hC0A0_0400);
        tally_and_finish;
    end
endmodule // tsm_status_merger_bench
